// ---- core/isp_pkg.sv ----
// constants and carriers for the serial programming host
// assumes a 10 MHz host clock; all wait counts derive from CLK_NS
package isp_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_NS = 100;
    localparam int T_PWR_US = 20000;    // settle after reset low
    localparam int T_FLASH_US = 4500;   // flash_page_wait_delay
    localparam int T_EE_US = 3600;      // eeprom_byte_wait_delay
    localparam int T_ERASE_US = 9000;   // chip erase wait
    localparam int T_RSTP_NS = 2000;    // reset high pulse for resync
    // least times round up to whole cycles
    localparam int PWR_CYC = (T_PWR_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int FLASH_CYC = (T_FLASH_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int EE_CYC = (T_EE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_CYC = (T_ERASE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int RSTP_CYC = (T_RSTP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCK_HALF_CYC = 8;    // half period of the serial clock
    localparam int MAX_TRIES = 4;       // enable attempts before giving up

    // ****************************************************************
    // frame layout and instruction bytes
    // ****************************************************************
    localparam int BYTE_W = 8;
    localparam int FRAME_W = 32;
    localparam int ADDR_W = 16;
    localparam int FL_AW = 13;          // flash word address width
    localparam int EE_AW = 10;          // eeprom byte address width
    localparam int PG_W = 6;            // word bits inside a flash page
    localparam int HI_POS = 3;          // high/low byte select in byte 1
    localparam int ECHO_LSB = 8;        // echo sits in the third byte
    localparam logic [7:0] OPC_PROG_EN = 8'hAC;
    localparam logic [7:0] SYNC_ECHO = 8'h53;
    localparam logic [7:0] ERASE_B2 = 8'h80;
    localparam logic [7:0] OPC_RD_FLASH = 8'h20;
    localparam logic [7:0] OPC_LD_FLASH = 8'h40;
    localparam logic [7:0] OPC_WR_PAGE = 8'h4C;
    localparam logic [7:0] OPC_RD_EE = 8'hA0;
    localparam logic [7:0] OPC_WR_EE = 8'hC0;
    localparam logic [7:0] PAGE_MASK = 8'hC0;
    localparam logic [7:0] BLANK = 8'hFF;
    localparam logic [7:0] ZERO_B = 8'h00;

    // ****************************************************************
    // command and answer carriers
    // ****************************************************************
    typedef enum logic [2:0] {
        ISP_OP_ENABLE,
        ISP_OP_ERASE,
        ISP_OP_LOAD_FLASH,
        ISP_OP_WRITE_PAGE,
        ISP_OP_READ_FLASH,
        ISP_OP_WRITE_EE,
        ISP_OP_READ_EE,
        ISP_OP_END
    } isp_op_e;

    typedef struct packed {
        isp_op_e op;
        logic hi;                       // high byte of a flash word
        logic poll;                     // complete by read-back polling
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } isp_cmd_s;

    typedef struct packed {
        logic ok;
        logic [BYTE_W-1:0] data;
    } isp_rsp_s;

endpackage

// ---- core/isp_host.sv ----
// serial programming host: drives reset, sck and mosi of the target
// assumes a target clock fast enough for SCK_HALF
//
// Behaviour
// [R01] program only while target reset held low
// [R02] enable first; others refused before
// [R03] eeprom write erases itself, no erase needed
// [R04] chip erase leaves both arrays all ones
// [R05] sck low and high phases long enough
// [R06] target must have a valid clock
// [R07] target samples mosi on sck rise
// [R08] target shifts miso on sck fall
// [R09] reset and sck low at power-up; pulse; host holds dev_reset_n high out of reset until an enable command
// [R10] wait 20 ms before programming enable
// [R11] target echoes second enable byte in third
// [R12] always shift all four instruction bytes
// [R13] no echo: pulse reset, resend enable
// [R14] flash loaded per byte with page word bits
// [R15] load low byte before high byte
// [R16] write page with upper address bits
// [R17] wait flash delay or poll before next
// [R18] eeprom one byte per write, then wait
// [R19] read returns addressed location on miso
// [R20] reset high ends session, normal running
// [R21] flash page reads ones while writing
// [R22] all-ones values use delay, not polling
// [R23] enable encoded AC 53 xx xx
// [R24] chip erase encoded AC 100x_xxxx xx xx
// [R25] eeprom address reads ones while writing
// [R26] four bytes, msb first both directions
`timescale 1ns/10ps

module isp_host
    import isp_pkg::*;
#(
    parameter int SCK_HALF = SCK_HALF_CYC,
    parameter int PWR_WAIT = PWR_CYC,
    parameter int FLASH_WAIT = FLASH_CYC,
    parameter int EE_WAIT = EE_CYC,
    parameter int ERASE_WAIT = ERASE_CYC,
    parameter int RST_PULSE = RSTP_CYC,
    parameter int TRIES = MAX_TRIES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    input wire isp_cmd_s cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output isp_rsp_s rsp,
    output logic session,
    input wire logic miso,
    output logic sck,
    output logic mosi,
    output logic dev_reset_n
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    localparam int WAIT_W = 24;
    localparam int PH_W = 8;
    localparam int TRY_W = 4;

    // sck phases must cover the miso synchroniser
    if (SCK_HALF < 3 || SCK_HALF >= (1 << PH_W)) begin : g_bad_half
        $error("SCK_HALF out of range");
    end
    if (PWR_WAIT < 1 || FLASH_WAIT < 1 || EE_WAIT < 1 ||
        ERASE_WAIT < 1 || RST_PULSE < 1) begin : g_bad_wait
        $error("wait counts below one");
    end
    if (PWR_WAIT >= (1 << WAIT_W) || ERASE_WAIT >= (1 << WAIT_W))
    begin : g_big_wait
        $error("wait too long");
    end
    if (TRIES < 1 || TRIES >= (1 << TRY_W)) begin : g_bad_tries
        $error("TRIES out of range");
    end

    typedef enum logic [1:0] {
        S_IDLE,
        S_RST_HI,
        S_PWR,
        S_XFER
    } isp_state_e;


    // ****************************************************************
    // frame builder
    // ****************************************************************
    // rd turns a write into a read of the same location
    function automatic logic [FRAME_W-1:0] isp_frame(
        input isp_cmd_s c,
        input logic rd
    );
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
        b1 = ZERO_B;
        b2 = 8'(c.addr[FL_AW-1:BYTE_W]);
        b3 = c.addr[BYTE_W-1:0];
        b4 = ZERO_B;
        unique case (c.op)
            ISP_OP_ENABLE: begin
                b1 = OPC_PROG_EN; // R23
                b2 = SYNC_ECHO;
            end
            ISP_OP_ERASE: begin
                b1 = OPC_PROG_EN; // R24
                b2 = ERASE_B2;
            end
            ISP_OP_LOAD_FLASH: begin
                b1 = OPC_LD_FLASH; // R14
                b1[HI_POS] = c.hi; // R15
                b2 = ZERO_B;
                b3 = 8'(c.addr[PG_W-1:0]);
                b4 = c.data;
            end
            ISP_OP_WRITE_PAGE: begin
                if (rd) begin
                    b1 = OPC_RD_FLASH; // R21
                    b1[HI_POS] = c.hi;
                end else begin
                    b1 = OPC_WR_PAGE; // R16
                    b3 = c.addr[BYTE_W-1:0] & PAGE_MASK;
                end
            end
            ISP_OP_READ_FLASH: begin
                b1 = OPC_RD_FLASH; // R19
                b1[HI_POS] = c.hi;
            end
            ISP_OP_WRITE_EE, ISP_OP_READ_EE: begin
                b1 = (c.op == ISP_OP_WRITE_EE && !rd) ? OPC_WR_EE
                                                      : OPC_RD_EE;
                b2 = 8'(c.addr[EE_AW-1:BYTE_W]); // R18
                b4 = (b1 == OPC_WR_EE) ? c.data : ZERO_B;
            end
            ISP_OP_END: begin
                b1 = ZERO_B;
            end
        endcase
        return {b1, b2, b3, b4};
    endfunction

    // ****************************************************************
    // miso synchroniser
    // ****************************************************************
    logic miso_m_q;
    logic miso_s_q;

    // async pin; only the second stage is read
    always_ff @(posedge clk) begin
        if (!resetn) begin
            miso_m_q <= 1'b0;
            miso_s_q <= 1'b0;
        end else begin
            miso_m_q <= miso;
            miso_s_q <= miso_m_q;
        end
    end

    // ****************************************************************
    // shift engine
    // ****************************************************************
    logic go_q;
    logic [FRAME_W-1:0] frame_q;
    logic active_q;
    logic done_q;
    logic sck_q;
    logic mosi_q;
    logic [PH_W-1:0] ph_q;
    logic [4:0] bit_q;
    logic [FRAME_W-1:0] sh_q;
    logic [FRAME_W-1:0] rx_q;

    // sck divided from clk; mosi moves on fall, miso taken at rise
    always_ff @(posedge clk) begin
        if (!resetn) begin
            active_q <= 1'b0;
            done_q <= 1'b0;
            sck_q <= 1'b0;
            mosi_q <= 1'b0;
            ph_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            rx_q <= '0;
        end else begin
            done_q <= 1'b0;
            if (go_q) begin
                active_q <= 1'b1;
                sh_q <= frame_q;
                mosi_q <= frame_q[FRAME_W-1]; // R26
                sck_q <= 1'b0;
                ph_q <= PH_W'(SCK_HALF - 1);
                bit_q <= 5'(FRAME_W - 1);
            end else if (active_q) begin
                if (ph_q != '0) begin
                    ph_q <= ph_q - 1'b1; // R05
                end else begin
                    ph_q <= PH_W'(SCK_HALF - 1);
                    if (!sck_q) begin
                        sck_q <= 1'b1; // R07
                        rx_q <= {rx_q[FRAME_W-2:0], miso_s_q}; // R08
                    end else begin
                        sck_q <= 1'b0;
                        if (bit_q == '0) begin
                            active_q <= 1'b0; // R12
                            done_q <= 1'b1;
                            mosi_q <= 1'b0;
                        end else begin
                            bit_q <= bit_q - 1'b1;
                            sh_q <= {sh_q[FRAME_W-2:0], 1'b0};
                            mosi_q <= sh_q[FRAME_W-2];
                        end
                    end
                end
            end
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    isp_state_e st_q;
    isp_cmd_s cmd_q;
    logic [WAIT_W-1:0] wait_q;
    logic [TRY_W-1:0] tries_q;
    logic waiting_q;
    logic poll_q;
    logic polling_q;
    logic session_q;
    logic dev_rst_n_q;
    logic cmd_ready_q;
    logic rsp_valid_q;
    isp_rsp_s rsp_q;
    logic [7:0] rx_byte;
    logic [7:0] rx_echo;

    assign rx_byte = rx_q[BYTE_W-1:0];
    assign rx_echo = rx_q[ECHO_LSB+BYTE_W-1:ECHO_LSB];

    // one command at a time; wait counter counts down in every state and holds at zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= S_IDLE;
            cmd_q <= '0;
            wait_q <= '0;
            tries_q <= '0;
            waiting_q <= 1'b0;
            poll_q <= 1'b0;
            polling_q <= 1'b0;
            session_q <= 1'b0;
            dev_rst_n_q <= 1'b1;
            cmd_ready_q <= 1'b1;
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
            go_q <= 1'b0;
            frame_q <= '0;
        end else begin
            go_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            if (wait_q != '0) begin
                wait_q <= wait_q - 1'b1;
            end
            unique case (st_q)
                S_IDLE: begin
                    if (waiting_q) begin
                        // self-timed write: wait, or poll
                        if (wait_q == '0) begin
                            waiting_q <= 1'b0; // R17
                            rsp_valid_q <= 1'b1;
                            rsp_q <= '{ok: 1'b1, data: BLANK};
                            cmd_ready_q <= 1'b1;
                        end else if (poll_q) begin
                            frame_q <= isp_frame(cmd_q, 1'b1);
                            go_q <= 1'b1;
                            polling_q <= 1'b1;
                            st_q <= S_XFER;
                        end
                    end else if (cmd_valid && cmd_ready_q) begin
                        cmd_q <= cmd;
                        cmd_ready_q <= 1'b0;
                        if (cmd.op == ISP_OP_ENABLE) begin
                            dev_rst_n_q <= 1'b0; // R01
                            session_q <= 1'b0;
                            tries_q <= '0;
                            wait_q <= WAIT_W'(PWR_WAIT); // R10
                            st_q <= S_PWR;
                        end else if (cmd.op == ISP_OP_END) begin
                            dev_rst_n_q <= 1'b1; // R20
                            session_q <= 1'b0;
                            rsp_valid_q <= 1'b1;
                            rsp_q <= '{ok: 1'b1, data: ZERO_B};
                            cmd_ready_q <= 1'b1;
                        end else if (!session_q) begin
                            rsp_valid_q <= 1'b1; // R02
                            rsp_q <= '{ok: 1'b0, data: ZERO_B};
                            cmd_ready_q <= 1'b1;
                        end else begin
                            frame_q <= isp_frame(cmd, 1'b0);
                            go_q <= 1'b1;
                            polling_q <= 1'b0;
                            st_q <= S_XFER;
                        end
                    end
                end
                S_RST_HI: begin
                    if (wait_q == '0) begin
                        dev_rst_n_q <= 1'b0; // R13
                        wait_q <= WAIT_W'(PWR_WAIT); // R10
                        st_q <= S_PWR;
                    end
                end
                S_PWR: begin
                    // sck low, reset held low
                    if (wait_q == '0) begin
                        frame_q <= isp_frame(cmd_q, 1'b0); // R09
                        go_q <= 1'b1;
                        st_q <= S_XFER;
                    end
                end
                S_XFER: begin
                    if (done_q) begin
                        st_q <= S_IDLE;
                        if (cmd_q.op == ISP_OP_ENABLE) begin
                            if (rx_echo == SYNC_ECHO) begin
                                session_q <= 1'b1; // R11
                                rsp_valid_q <= 1'b1;
                                rsp_q <= '{ok: 1'b1, data: rx_echo};
                                cmd_ready_q <= 1'b1;
                            end else if (tries_q == TRY_W'(TRIES - 1)) begin
                                rsp_valid_q <= 1'b1;
                                rsp_q <= '{ok: 1'b0, data: rx_echo};
                                cmd_ready_q <= 1'b1;
                            end else begin
                                tries_q <= tries_q + 1'b1;
                                dev_rst_n_q <= 1'b1; // R13
                                wait_q <= WAIT_W'(RST_PULSE); // R09
                                st_q <= S_RST_HI;
                            end
                        end else if (polling_q) begin
                            // ones mean the write is still running
                            if (rx_byte == cmd_q.data) begin
                                waiting_q <= 1'b0; // R21
                                wait_q <= '0;
                                rsp_valid_q <= 1'b1; // R25
                                rsp_q <= '{ok: 1'b1, data: rx_byte};
                                cmd_ready_q <= 1'b1;
                            end
                        end else if (cmd_q.op == ISP_OP_ERASE) begin
                            waiting_q <= 1'b1; // R04
                            poll_q <= 1'b0;
                            wait_q <= WAIT_W'(ERASE_WAIT);
                        end else if (cmd_q.op == ISP_OP_WRITE_PAGE ||
                                     cmd_q.op == ISP_OP_WRITE_EE) begin
                            // ones look busy
                            waiting_q <= 1'b1;
                            poll_q <= cmd_q.poll &&
                                      (cmd_q.data != BLANK); // R22
                            wait_q <= (cmd_q.op == ISP_OP_WRITE_PAGE) ?
                                      WAIT_W'(FLASH_WAIT) :
                                      WAIT_W'(EE_WAIT); // R03
                        end else begin
                            rsp_valid_q <= 1'b1; // R19
                            rsp_q <= '{ok: 1'b1, data: rx_byte};
                            cmd_ready_q <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // all straight from flip-flops
    assign cmd_ready = cmd_ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp = rsp_q;
    assign session = session_q;
    assign sck = sck_q;
    assign mosi = mosi_q;
    assign dev_reset_n = dev_rst_n_q; // R06

endmodule

// ---- tb/isp_host_assertions.sv ----
// checker for the serial programming host, top ports only
// assumes bind to isp_host, serial clock half period of 8 cycles
`timescale 1ns/10ps
module isp_host_checker
    import isp_pkg::*;
#(
    parameter int PWR_WAIT = PWR_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    input wire isp_cmd_s cmd,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire isp_rsp_s rsp,
    input wire logic session,
    input wire logic miso,
    input wire logic sck,
    input wire logic mosi,
    input wire logic dev_reset_n
);
    // ****************************************************************
    // link and command checks
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    int low_q;
    logic take;
    logic mem_op;
    assign take = cmd_valid && cmd_ready;
    assign mem_op = cmd.op != ISP_OP_ENABLE && cmd.op != ISP_OP_END;

    // cycles with target reset low, saturating
    always_ff @(posedge clk) begin
        if (!resetn || dev_reset_n) begin
            low_q <= 0;
        end else if (low_q < PWR_WAIT) begin
            low_q <= low_q + 1;
        end
    end

    AST_SCK_IN_PROG: assert property (sck |-> !dev_reset_n)
        else $error("sck outside programming");
    AST_SCK_HIGH: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
        else $error("sck high phase wrong");
    AST_SCK_LOW: assert property ($fell(sck) |-> (!sck)[*8])
        else $error("sck low phase too short");
    AST_MOSI_HOLD: assert property (sck |-> $stable(mosi))
        else $error("mosi moved, sck high");
    AST_WAIT_POWER: assert property ($rose(sck) |-> low_q >= PWR_WAIT)
        else $error("frame too soon");
    AST_REFUSE: assert property (take && !session && mem_op
        |-> ##[1:2] (rsp_valid && !rsp.ok && !sck))
        else $error("op taken without session");
    AST_SESSION_LOW: assert property (session |-> !dev_reset_n)
        else $error("session, reset high");
    AST_END_RELEASE: assert property (take && cmd.op == ISP_OP_END
        |-> ##[1:3] dev_reset_n)
        else $error("end kept target reset");
endmodule

bind isp_host isp_host_checker #(
    .PWR_WAIT(PWR_WAIT)
) u_chk (
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .session(session), .miso(miso), .sck(sck), .mosi(mosi),
    .dev_reset_n(dev_reset_n)
);

// ---- tb/isp_target_model.sv ----
// behavioural serial programming target with flash and eeprom
// assumes host drives sck and mosi; clk is the target clock
`timescale 1ns/10ps
module isp_target_model
    import isp_pkg::*;
#(
    parameter int BUSY_NS = 3500
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic desync,
    output logic miso
);
    // ****************************************************************
    // arrays and link state
    // ****************************************************************
    logic [7:0] fl [0:16383];
    logic [7:0] ee [0:1023];
    logic [7:0] pbuf [0:127] = '{default: 8'hFF};
    logic [31:0] rx = 32'h0;
    logic [31:0] f;
    logic [7:0] tx = 8'h00;
    logic [4:0] cnt = 5'h0;
    logic on_q = 1'b0;
    logic junk_q = 1'b0;
    logic [6:0] bpage = 7'h0;
    logic [9:0] baddr = 10'h0;
    time fl_end = 0;
    time ee_end = 0;

    // released pin toggles, no stale bit
    always @(posedge clk) begin
        junk_q <= ~junk_q;
    end
    assign miso = rst_n ? junk_q : tx[7];

    // read reply; busy reads blank
    function automatic logic [7:0] reply(input logic [23:0] q);
        if (!on_q) return ZERO_B;
        if ((q[23:16] & 8'hF7) == OPC_RD_FLASH) begin
            if ($time < fl_end && q[12:6] == bpage) return BLANK;
            return fl[{q[12:0], q[19]}];
        end
        if (q[23:16] == OPC_RD_EE) begin
            if ($time < ee_end && q[9:0] == baddr) return BLANK;
            return ee[q[9:0]];
        end
        return ZERO_B;
    endfunction

    // mosi taken on sck rise; act on last bit
    always @(posedge sck or posedge rst_n) begin
        if (rst_n) begin
            cnt = 5'h0;
            on_q = 1'b0;
        end else begin
            f = {rx[30:0], mosi};
            rx = f;
            cnt = cnt + 5'h1;
            if (cnt == 5'h0 && f[31:16] == {OPC_PROG_EN, SYNC_ECHO}) begin
                on_q = !desync;
            end else if (cnt == 5'h0 && on_q) begin
                if (f[31:24] == OPC_PROG_EN && f[23:21] == 3'h4) begin
                    for (int i = 0; i < 16384; i++) fl[i] = BLANK;
                    for (int i = 0; i < 1024; i++) ee[i] = BLANK;
                end else if ((f[31:24] & 8'hF7) == OPC_LD_FLASH) begin
                    pbuf[{f[13:8], f[27]}] = f[7:0];
                end else if (f[31:24] == OPC_WR_PAGE) begin
                    bpage = {f[20:16], f[15:14]};
                    for (int i = 0; i < 128; i++) begin
                        fl[{bpage, 7'(i)}] &= pbuf[i];
                        pbuf[i] = BLANK;
                    end
                    fl_end = $time + BUSY_NS;
                end else if (f[31:24] == OPC_WR_EE) begin
                    baddr = f[17:8];
                    ee[baddr] = f[7:0];
                    ee_end = $time + BUSY_NS;
                end
            end
        end
    end

    // reply shifted out on sck fall, msb first
    always @(negedge sck) begin
        if (cnt == 5'h10) begin
            tx = desync ? ZERO_B : rx[7:0];
        end else if (cnt == 5'h18) begin
            tx = reply(rx[23:0]);
        end else begin
            tx = {tx[6:0], 1'b0};
        end
    end
endmodule

// ---- tb/isp_host_bench.sv ----
// self-checking bench for the serial programming host
// assumes the target model on the far side
`timescale 1ns/10ps
module isp_host_bench
    import isp_pkg::*;
;
    // ****************************************************************
    // stimulus, target and checks
    // ****************************************************************
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid = 1'b0;
    isp_cmd_s cmd = '0;
    logic cmd_ready, rsp_valid, session, miso, sck, mosi, dev_reset_n;
    isp_rsp_s rsp, r;
    logic desync = 1'b0;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 32'h094b903a;
    logic [7:0] fl_ref [int];
    logic [15:0] a, pg, w;
    logic [7:0] d;

    always #50 clk = ~clk;

    isp_host #(
        .PWR_WAIT(50), .FLASH_WAIT(40), .EE_WAIT(40),
        .ERASE_WAIT(60), .RST_PULSE(20)
    ) u_dut (
        .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
        .session(session), .miso(miso), .sck(sck), .mosi(mosi),
        .dev_reset_n(dev_reset_n)
    );
    // target runs on the bench clock
    isp_target_model u_target (
        .clk(clk), .rst_n(dev_reset_n), .sck(sck), .mosi(mosi),
        .desync(desync), .miso(miso)
    );

    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask

    task automatic complete_run();
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one command, held until taken; answer waited on a bounded count
    task automatic run(input isp_op_e op, input logic hi, input logic poll,
                       input logic [15:0] ad, input logic [7:0] dt);
        int n;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op: op, hi: hi, poll: poll, addr: ad, data: dt};
        do @(negedge clk); while (cmd_ready !== 1'b1);
        @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 9000);
        r = rsp;
        check({8'h00, n < 9000}, 9'h001);
    endtask

    // run needs about 30k cycles
    initial begin
        #6000000;
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check({3'h0, cmd_ready, rsp_valid, session, sck, mosi, dev_reset_n},
              9'h021);
        // no session: memory ops refused
        for (int op = 1; op < 7; op++) begin
            run(isp_op_e'(op), 1'b0, 1'b0, 16'($random(seed)), 8'h5A);
            check({8'h00, r.ok, dev_reset_n}, 9'h001);
        end
        // no echo: host gives up
        desync <= 1'b1;
        run(ISP_OP_ENABLE, 1'b0, 1'b0, 16'h0000, ZERO_B);
        check({7'h00, r.ok, session}, 9'h000);
        run(ISP_OP_END, 1'b0, 1'b0, 16'h0000, ZERO_B);
        check({8'h00, dev_reset_n}, 9'h001);
        // first try fails, reset pulse resyncs
        fork @(posedge dev_reset_n) desync <= 1'b0; join_none
        run(ISP_OP_ENABLE, 1'b0, 1'b0, 16'h0000, ZERO_B);
        check(r, {1'b1, SYNC_ECHO});
        run(ISP_OP_ERASE, 1'b0, 1'b0, 16'h0000, ZERO_B);
        check({8'h00, r.ok}, 9'h001);
        for (int i = 0; i < 3; i++) begin
            a = 16'($random(seed)) & 16'h1FFF;
            run(ISP_OP_READ_FLASH, i[0], 1'b0, a, ZERO_B);
            check(r, {1'b1, BLANK});
            run(ISP_OP_READ_EE, 1'b0, 1'b0, a & 16'h03FF, ZERO_B);
            check(r, {1'b1, BLANK});
        end
        // two pages, edge words, polled then timed
        pg = 16'($random(seed)) & 16'h1FC0;
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
                w = pg | ((k < 2) ? 16'(k * 63) : 16'($random(seed) & 63));
                for (int h = 0; h < 2; h++) begin
                    d = 8'($random(seed));
                    fl_ref[{w, h[0]}] = d;
                    run(ISP_OP_LOAD_FLASH, h[0], 1'b0, w, d);
                end
            end
            run(ISP_OP_WRITE_PAGE, 1'b0, p == 0, pg, fl_ref[{pg, 1'b0}]);
            check({8'h00, r.ok}, 9'h001);
            pg = pg ^ 16'h0040;
        end
        foreach (fl_ref[k]) begin
            run(ISP_OP_READ_FLASH, k[0], 1'b0, 16'(k >> 1), ZERO_B);
            check(r, {1'b1, fl_ref[k]});
        end
        // ee rewrites without erase
        for (int i = 0; i < 4; i++) begin
            a = 16'($random(seed)) & 16'h03FF;
            d = 8'($random(seed));
            run(ISP_OP_WRITE_EE, 1'b0, i[0], a, d);
            check({8'h00, r.ok}, 9'h001);
            run(ISP_OP_READ_EE, 1'b0, 1'b0, a, ZERO_B);
            check(r, {1'b1, d});
        end
        run(ISP_OP_END, 1'b0, 1'b0, 16'h0000, ZERO_B);
        check({7'h00, dev_reset_n, session}, 9'h002);
        run(ISP_OP_READ_EE, 1'b0, 1'b0, 16'h0000, ZERO_B);
        check({8'h00, r.ok}, 9'h000);
        complete_run();
    end
endmodule
